// [option_bit_loader_trim_access.sv]
// option byte loader and trim working copy with an AXI4-Lite slave
// assumes single-clock flash with a hold-until-ack read port
`timescale 1ns/1ns
`include "trim_loader_consts.svh"

module option_bit_loader_trim_access
   import trim_loader_pkg::*;
(
   // clock and reset
   input  wire logic           aclk,
   input  wire logic           aresetn,
   // stop-mode recovery or system reset, one-cycle pulse
   input  wire logic           reload_req,
   // processor reset hold
   output logic                cpu_reset_n,
   // axi4-lite write address and data
   input  wire logic [15:0]    awaddr,
   input  wire logic           awvalid,
   output logic                awready,
   input  wire logic [31:0]    wdata,
   input  wire logic [3:0]     wstrb,
   input  wire logic           wvalid,
   output logic                wready,
   // axi4-lite write response
   output logic [1:0]          bresp,
   output logic                bvalid,
   input  wire logic           bready,
   // axi4-lite read
   input  wire logic [15:0]    araddr,
   input  wire logic           arvalid,
   output logic                arready,
   output logic [31:0]         rdata,
   output logic [1:0]          rresp,
   output logic                rvalid,
   input  wire logic           rready,
   // flash array read port
   output flash_cmd_type       flash_cmd,
   input  wire logic [7:0]     flash_data,
   input  wire logic           flash_ack,
   // processor constant-load port
   input  wire logic           cld_req,
   input  wire logic [15:0]    cld_addr,
   output logic [7:0]          cld_data,
   output logic                cld_ack,
   // configuration towards the rest of the chip
   output logic [7:0]          option_byte0,
   output logic [7:0]          option_byte1,
   output logic [255:0]        trim_working
);

   localparam int LOAD_BOUND = 1000;

   // loader
   flash_cmd_type  fetch_cmd;
   load_write_type load_wr;
   logic           load_busy;
   logic           load_done;
   wire            loading = !load_done;

   fetch_sequencer u_fetch (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .start      (reload_req),
      .cmd        (fetch_cmd),
      .flash_data (flash_data),
      .flash_ack  (flash_ack && loading),
      .load_wr    (load_wr),
      .busy       (load_busy),
      .done       (load_done)
   );

   // a registered hold avoids a glitch on the processor reset line
   always_ff @(posedge aclk) begin
      if (!aresetn) cpu_reset_n <= 1'b0;
      else cpu_reset_n <= load_done && !reload_req;
   end

   // hidden option registers, written by the loader alone
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         option_byte0 <= `OPTION_ERASED;
         option_byte1 <= `OPTION_ERASED;
      end else if (load_wr.valid) begin
         // erased flash reads back as all ones, so a wiped page 0 lands here
         if (load_wr.step == 6'h00) option_byte0 <= load_wr.data;
         if (load_wr.step == 6'h01) option_byte1 <= load_wr.data;
      end
   end

   // software registers
   logic [7:0] trim_index;
   logic [7:0] page_select_register;
   logic [7:0] trim_byte [`TRIM_COUNT];
   wire        idx_valid = (trim_index <= `TRIM_LAST_INDEX);
   wire        info_en   = page_select_register[`INFO_EN_BIT];

   // axi write channel
   logic        aw_held;
   logic        w_held;
   logic [13:0] aw_index;
   logic [7:0]  w_byte;
   logic        w_lane0;
   wire         aw_take  = awvalid && awready;
   wire         w_take   = wvalid && wready;
   wire         do_write = aw_held && w_held && !bvalid;
   wire         wr_lane  = do_write && w_lane0;
   wire         wr_idx   = (aw_index == `TRIM_INDEX_IDX);
   wire         wr_win   = (aw_index == `TRIM_WINDOW_IDX);
   wire         wr_page  = (aw_index == `PAGE_SELECT_IDX);
   wire         wr_stat  = (aw_index == `LOADER_STATUS_IDX);
   wire         wr_map   = wr_idx || wr_win || wr_page || wr_stat;
   wire         window_wr = wr_lane && wr_win && idx_valid;

   assign awready = !aw_held;
   assign wready  = !w_held;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held  <= 1'b0;
         aw_index <= 14'h0000;
      end else if (aw_take) begin
         aw_held  <= 1'b1;
         aw_index <= awaddr[15:`REG_ADDR_LSB];
      end else if (do_write) begin
         aw_held  <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held  <= 1'b0;
         w_byte  <= 8'h00;
         w_lane0 <= 1'b0;
      end else if (w_take) begin
         w_held  <= 1'b1;
         w_byte  <= wdata[7:0];
         w_lane0 <= wstrb[0];
      end else if (do_write) begin
         w_held  <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp  <= `RESP_OKAY;
      end else if (do_write) begin
         bvalid <= 1'b1;
         bresp  <= wr_map ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // index register, kept whole so software reads back what it wrote
   always_ff @(posedge aclk) begin
      if (!aresetn) trim_index <= `TRIM_INDEX_RESET;
      else if (wr_lane && wr_idx) trim_index <= w_byte;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) page_select_register <= `PAGE_SELECT_RESET;
      else if (wr_lane && wr_page) page_select_register <= w_byte;
   end

   // working trim copy; factory bytes stay in flash untouched
   genvar g;
   generate
      for (g = 0; g < `TRIM_COUNT; g++) begin : gen_trim
         wire ld_hit = load_wr.valid && (load_wr.step == 6'(g + 2));
         wire sw_hit = window_wr && (trim_index == 8'(g));
         // loader wins over software, the copy must be factory after reset
         always_ff @(posedge aclk) begin
            if (!aresetn) trim_byte[g] <= `TRIM_BYTE_RESET;
            else if (ld_hit) trim_byte[g] <= load_wr.data;
            else if (sw_hit) trim_byte[g] <= w_byte;
         end
         assign trim_working[g*8 +: 8] = trim_byte[g];
      end
   endgenerate

   // window read value; out-of-range index reads zero
   wire [7:0] window_value = idx_valid ? trim_byte[trim_index[4:0]] : `TRIM_WINDOW_RESET;

   // axi read channel
   wire [13:0] ar_index = araddr[15:`REG_ADDR_LSB];
   wire        rd_idx   = (ar_index == `TRIM_INDEX_IDX);
   wire        rd_win   = (ar_index == `TRIM_WINDOW_IDX);
   wire        rd_page  = (ar_index == `PAGE_SELECT_IDX);
   wire        rd_stat  = (ar_index == `LOADER_STATUS_IDX);
   wire        rd_map   = rd_idx || rd_win || rd_page || rd_stat;
   wire [7:0]  status   = {6'h00, load_busy, load_done};
   wire [7:0]  rd_byte  = rd_idx  ? trim_index :
                          rd_win  ? window_value :
                          rd_page ? page_select_register :
                          rd_stat ? status : 8'h00;
   wire        ar_take  = arvalid && arready;

   assign arready = !rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata  <= 32'h0000_0000;
         rresp  <= `RESP_OKAY;
      end else if (ar_take) begin
         rvalid <= 1'b1;
         rdata  <= {24'h00_0000, rd_byte};
         rresp  <= rd_map ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end

   // constant loads see the info page at the top while selected
   // calibration, serial and lot bytes live there, never in the trim map
   wire        cld_info  = info_en && (cld_addr >= `INFO_WINDOW_BASE);
   wire [15:0] cld_flash = cld_info ? (cld_addr & `INFO_OFFSET_MASK) : cld_addr;
   // the ack cycle blocks the request so a held request is not read twice
   wire        cld_go    = cld_req && !cld_ack;

   assign flash_cmd = loading ? fetch_cmd : {cld_go, cld_info, cld_flash};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cld_ack  <= 1'b0;
         cld_data <= 8'h00;
      end else begin
         cld_ack <= !loading && cld_go && flash_ack;
         if (!loading && cld_go && flash_ack) cld_data <= flash_data;
      end
   end

   // checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_reload;
      reload_req;
   endsequence

   sequence s_load_finish;
      !load_done ##[1:LOAD_BOUND] load_done;
   endsequence

   AST_HOLD_CPU: assert property (!load_done |=> !cpu_reset_n)
      else $error("processor released before load finished");

   AST_RELOAD: assert property (s_reload |=> s_load_finish)
      else $error("reload did not complete a fresh load");

   AST_OPTION_FROZEN: assert property (
      load_done && !load_wr.valid |=> $stable(option_byte0) && $stable(option_byte1))
      else $error("option bytes changed outside a load");

   // a fresh load must open at the lowest program byte
   AST_FIRST_FETCH: assert property (
      $past(reload_req) && !reload_req
      |-> flash_cmd.valid && !flash_cmd.info && flash_cmd.addr == 16'h0000)
      else $error("reload did not start at option byte 0000H");

   AST_OPTION_ADDR: assert property (
      loading && flash_cmd.valid && !flash_cmd.info |-> flash_cmd.addr <= 16'h0001)
      else $error("option fetch outside bytes 0000H-0001H");

   AST_TRIM_RANGE: assert property (
      loading && flash_cmd.valid && flash_cmd.info
      |-> flash_cmd.addr >= `TRIM_INFO_BASE && flash_cmd.addr <= `TRIM_INFO_LAST)
      else $error("trim fetch outside info offsets 20-3F");

   AST_WINDOW_WRITE: assert property (
      window_wr && !load_wr.valid |=> window_value == $past(w_byte))
      else $error("window write not seen at selected index");

   AST_OOR_READ: assert property (
      ar_take && rd_win && !idx_valid |=> rdata == 32'h0000_0000)
      else $error("out-of-range index did not read zero");

   AST_READ_WINDOW: assert property (
      ar_take && rd_win |=> rvalid && rdata[7:0] == $past(window_value))
      else $error("window read returned wrong byte");

   AST_INFO_MAP: assert property (
      !loading && cld_go && info_en && cld_addr >= `INFO_WINDOW_BASE
      |-> flash_cmd.info && flash_cmd.addr == (cld_addr & `INFO_OFFSET_MASK))
      else $error("info page not mapped at FE00H-FFFFH");

   AST_UNMAPPED: assert property (
      do_write && !wr_map |=> bvalid && bresp == `RESP_SLVERR)
      else $error("unmapped write not refused");

   AST_TRIM_LOADED: assert property (
      load_wr.valid && load_wr.step == 6'h02 |=> trim_byte[0] == $past(load_wr.data))
      else $error("factory trim not copied to working byte");

endmodule

// [trim_loader_consts.svh]
// register indices, field positions, reset values and fetch counts
// assumes inclusion by the loader top, the fetch sequencer and the bench, by bare name
`ifndef TRIM_LOADER_CONSTS_SVH
`define TRIM_LOADER_CONSTS_SVH

// register indices; byte address is four times the index
`define LOADER_STATUS_IDX  14'h0FF0
`define TRIM_INDEX_IDX     14'h0FF6
`define TRIM_WINDOW_IDX    14'h0FF7
`define PAGE_SELECT_IDX    14'h0FF9
`define REG_ADDR_LSB       2

// reset values
`define TRIM_INDEX_RESET   8'h00
`define TRIM_WINDOW_RESET  8'h00
`define PAGE_SELECT_RESET  8'h00
`define TRIM_BYTE_RESET    8'h00
`define OPTION_ERASED      8'hFF

// field positions
`define INFO_EN_BIT        7
`define STATUS_DONE_BIT    0
`define STATUS_BUSY_BIT    1

// trim and fetch geometry
`define TRIM_COUNT         32
`define TRIM_LAST_INDEX    8'h1F
`define OPTION_STEPS       6'h02
`define FETCH_LAST_STEP    6'h21
`define TRIM_INFO_BASE     16'h0020
`define TRIM_INFO_LAST     16'h003F
`define INFO_WINDOW_BASE   16'hFE00
`define INFO_OFFSET_MASK   16'h01FF

// bus answers
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// [trim_loader_pkg.sv]
// types shared by the loader top and its fetch sequencer
// assumes the constants header is on the include path
package trim_loader_pkg;

   // one read request towards the flash array
   typedef struct packed {
      logic        valid;
      logic        info;
      logic [15:0] addr;
   } flash_cmd_type;

   // one byte fetched during the reset-time load
   typedef struct packed {
      logic       valid;
      logic [5:0] step;
      logic [7:0] data;
   } load_write_type;

   typedef enum logic [1:0] {
      FETCH_RUN  = 2'b01,
      FETCH_DONE = 2'b10
   } fetch_state_type;

endpackage

// [fetch_sequencer.sv]
// walks the reset-time fetch: two option bytes, then 32 trim bytes
// assumes flash holds a request stable until it answers with ack
`timescale 1ns/1ns
`include "trim_loader_consts.svh"

module fetch_sequencer
   import trim_loader_pkg::*;
(
   // clock and reset
   input  wire logic           aclk,
   input  wire logic           aresetn,
   // restart request
   input  wire logic           start,
   // flash side
   output flash_cmd_type       cmd,
   input  wire logic [7:0]     flash_data,
   input  wire logic           flash_ack,
   // fetched bytes and progress
   output load_write_type      load_wr,
   output logic                busy,
   output logic                done
);

   fetch_state_type state;
   fetch_state_type next_state;
   logic [5:0]      step;
   wire             take = (state == FETCH_RUN) && flash_ack;
   wire             last = (step == `FETCH_LAST_STEP);
   wire             is_trim = (step >= `OPTION_STEPS);
   wire [15:0]      trim_addr = `TRIM_INFO_BASE + {10'h000, step} - {10'h000, `OPTION_STEPS};

   always_comb begin
      next_state = state;
      case (state)
         FETCH_RUN:  if (take && last) next_state = FETCH_DONE;
         FETCH_DONE: next_state = FETCH_DONE;
         default:    next_state = FETCH_RUN;
      endcase
      if (start) next_state = FETCH_RUN;
   end

   // reset lands in the run state, so every reset reloads
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= FETCH_RUN;
         step  <= 6'h00;
      end else begin
         state <= next_state;
         if (start) step <= 6'h00;
         else if (take && !last) step <= step + 6'h01;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         load_wr <= '0;
      end else begin
         load_wr.valid <= take && !start;
         load_wr.step  <= step;
         load_wr.data  <= flash_data;
      end
   end

   // option bytes at the bottom of program space, trim inside 20..3F
   assign cmd.valid = (state == FETCH_RUN) && !start;
   assign cmd.info  = is_trim;
   assign cmd.addr  = is_trim ? trim_addr : {10'h000, step};
   assign busy      = (state == FETCH_RUN) || load_wr.valid;
   // done waits for the last byte to land
   assign done      = (state == FETCH_DONE) && !load_wr.valid;

endmodule

// [flash_model.sv]
// flash array model: option bytes at 0000H/0001H and a 512-byte info page
// assumes the loader holds each read request stable until ack
`timescale 1ns/1ns

module flash_model
   import trim_loader_pkg::*;
(
   // clock and reset
   input  wire logic       aclk,
   input  wire logic       aresetn,
   // read port
   input  flash_cmd_type   cmd,
   output logic [7:0]      data,
   output logic            ack,
   // answer delay in cycles
   input  wire logic [3:0] delay
);
   logic [7:0] prog [0:1];
   logic [7:0] info [0:511];
   logic [3:0] cnt;
   wire        low2 = (cmd.addr[15:1] == 15'h0000);
   wire  [7:0] prog_rd = low2 ? prog[cmd.addr[0]] : 8'h5A;
   wire  [7:0] rd = cmd.info ? info[cmd.addr[8:0]] : prog_rd;

   // factory data; info page never written again, program bytes rewritten by erase_prog and program_opt
   initial begin
      prog[0] = 8'hA5;
      prog[1] = 8'hF7;
      for (int i = 0; i < 512; i++)
         info[i] = 8'(i) ^ 8'hC3;
   end

   // erase hits program memory only; info page survives
   task automatic erase_prog();
      prog[0] = 8'hFF;
      prog[1] = 8'hFF;
   endtask

   task automatic program_opt(input logic [7:0] b0, input logic [7:0] b1);
      prog[0] = b0;
      prog[1] = b1;
   endtask

   // idle data toggles so a stale byte is never mistaken for an answer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ack  <= 1'b0;
         cnt  <= 4'h0;
         data <= 8'h00;
      end else begin
         data <= ~data;
         ack  <= 1'b0;
         if (!ack && cmd.valid && cnt >= delay) begin
            ack  <= 1'b1;
            data <= rd;
            cnt  <= 4'h0;
         end else if (!ack && cmd.valid)
            cnt <= cnt + 4'h1;
      end
   end
endmodule

// [option_bit_loader_trim_access_tb.sv]
// self-checking bench for the option loader and trim window
// assumes the flash model answers every held request
`timescale 1ns/1ns
`include "trim_loader_consts.svh"

module option_bit_loader_trim_access_tb
   import trim_loader_pkg::*;
;
   typedef struct packed {
      logic        rd;
      logic [15:0] a;
      logic [31:0] d;
      logic [1:0]  resp;
   } row_type;

   localparam logic [15:0] a_idx = {`TRIM_INDEX_IDX, 2'b00};
   localparam logic [15:0] a_win = {`TRIM_WINDOW_IDX, 2'b00};
   localparam logic [15:0] a_pg  = {`PAGE_SELECT_IDX, 2'b00};
   localparam logic [15:0] a_st  = {`LOADER_STATUS_IDX, 2'b00};
   localparam logic [1:0]  ok    = `RESP_OKAY;
   localparam logic [1:0]  err   = `RESP_SLVERR;
   localparam row_type rows [16] = '{
      '{1'b0, a_idx, 32'h00, ok}, '{1'b1, a_win, 32'hE3, ok},
      '{1'b0, a_idx, 32'h1F, ok}, '{1'b1, a_win, 32'hFC, ok},
      '{1'b0, a_win, 32'h5A, ok}, '{1'b1, a_win, 32'h5A, ok},
      '{1'b1, a_idx, 32'h1F, ok}, '{1'b0, a_idx, 32'h20, ok},
      '{1'b1, a_win, 32'h00, ok}, '{1'b0, a_win, 32'h77, ok},
      '{1'b1, a_idx, 32'h20, ok}, '{1'b0, a_idx, 32'h1F, ok},
      '{1'b1, a_win, 32'h5A, ok}, '{1'b0, 16'h0100, 32'h00, err},
      '{1'b1, 16'h0100, 32'h00, err}, '{1'b1, a_st, 32'h01, ok}};

   logic          aclk = 1'b0;
   logic          aresetn = 1'b0;
   logic          reload_req = 1'b0;
   logic          awvalid = 1'b0;
   logic          wvalid = 1'b0;
   logic          bready = 1'b0;
   logic          arvalid = 1'b0;
   logic          rready = 1'b0;
   logic          cld_req = 1'b0;
   logic [15:0]   awaddr = 16'h0000;
   logic [15:0]   araddr = 16'h0000;
   logic [15:0]   cld_addr = 16'h0000;
   logic [31:0]   wdata = 32'h0000_0000;
   logic [3:0]    delay = 4'h0;
   logic [3:0]    wstrb = 4'hF;
   logic          cpu_reset_n, awready, wready, bvalid, arready, rvalid;
   logic          cld_ack, flash_ack;
   logic [1:0]    bresp, rresp, r;
   logic [31:0]   rdata, d;
   logic [7:0]    cld_data, flash_data, option_byte0, option_byte1;
   logic [255:0]  trim_working;
   flash_cmd_type flash_cmd;
   int            fails = 0;
   int            n_checks = 0;

   option_bit_loader_trim_access u_dut (
      .aclk(aclk), .aresetn(aresetn), .reload_req(reload_req),
      .cpu_reset_n(cpu_reset_n), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready), .flash_cmd(flash_cmd),
      .flash_data(flash_data), .flash_ack(flash_ack), .cld_req(cld_req),
      .cld_addr(cld_addr), .cld_data(cld_data), .cld_ack(cld_ack),
      .option_byte0(option_byte0), .option_byte1(option_byte1),
      .trim_working(trim_working));

   flash_model u_flash (
      .aclk(aclk), .aresetn(aresetn), .cmd(flash_cmd), .data(flash_data),
      .ack(flash_ack), .delay(delay));

   initial begin
      forever #25 aclk = ~aclk;
   end

   function automatic logic [255:0] exp_trim();
      logic [255:0] v;
      for (int g = 0; g < 32; g++)
         v[g*8+:8] = 8'(g + 32) ^ 8'hC3;
      return v;
   endfunction

   task automatic check(input logic [255:0] seen, input logic [255:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("comparisons %0d, mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic tmo();
      fails++;
      report_and_stop();
   endtask

   task automatic axi_write(input logic [15:0] a, input logic [31:0] v);
      logic pa, pw, pb;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= v;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (int i = 0; i < 100; i++) begin
         @(negedge aclk);
         pa = awvalid && awready;
         pw = wvalid && wready;
         pb = bvalid;
         r  = bresp;
         @(posedge aclk);
         if (pa)
            awvalid <= 1'b0;
         if (pw)
            wvalid <= 1'b0;
         if (pb) begin
            bready <= 1'b0;
            return;
         end
      end
      tmo();
   endtask

   task automatic axi_read(input logic [15:0] a);
      logic pa, pr;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (int i = 0; i < 100; i++) begin
         @(negedge aclk);
         pa = arvalid && arready;
         pr = rvalid;
         d  = rdata;
         r  = rresp;
         @(posedge aclk);
         if (pa)
            arvalid <= 1'b0;
         if (pr) begin
            rready <= 1'b0;
            return;
         end
      end
      tmo();
   endtask

   task automatic cld(input logic [15:0] a, input logic [7:0] e);
      @(posedge aclk);
      cld_addr <= a;
      cld_req  <= 1'b1;
      for (int i = 0; i < 100; i++) begin
         @(negedge aclk);
         if (cld_ack === 1'b1) begin
            check(cld_data, e);
            @(posedge aclk);
            cld_req <= 1'b0;
            return;
         end
      end
      tmo();
   endtask

   task automatic wait_load();
      for (int i = 0; i < 500; i++) begin
         @(negedge aclk);
         if (cpu_reset_n === 1'b1)
            return;
      end
      tmo();
   endtask

   // reload pulse, then the processor must sit in reset at once
   task automatic reload();
      @(posedge aclk);
      reload_req <= 1'b1;
      @(posedge aclk);
      reload_req <= 1'b0;
      @(negedge aclk);
      check(cpu_reset_n, 1'b0);
      axi_read(a_st);
      check(d, 32'h02);
      wait_load();
   endtask

   initial begin
      repeat (3) @(posedge aclk);
      check(cpu_reset_n, 1'b0);
      aresetn <= 1'b1;
      wait_load();
      check(trim_working, exp_trim());
      check({option_byte1, option_byte0}, 16'hF7A5);
      axi_read(a_idx);
      check(d, 32'h00);
      axi_read(a_pg);
      check(d, 32'h00);
      for (int k = 0; k < 16; k++) begin
         if (rows[k].rd) begin
            axi_read(rows[k].a);
            check(d, rows[k].d);
         end else
            axi_write(rows[k].a, rows[k].d);
         check(r, rows[k].resp);
      end
      // lane 0 strobe low: window write must leave the byte alone
      wstrb <= 4'h0;
      axi_write(a_win, 32'h33);
      check(r, ok);
      wstrb <= 4'hF;
      check(trim_working[255:248], 8'h5A);
      check(option_byte0, 8'hA5);
      // new option bytes must wait for the next reset
      u_flash.program_opt(8'h3C, 8'hEF);
      repeat (5) @(posedge aclk);
      check({option_byte1, option_byte0}, 16'hF7A5);
      delay <= 4'h3;
      reload();
      check({option_byte1, option_byte0}, 16'hEF3C);
      check(trim_working, exp_trim());
      u_flash.erase_prog();
      delay <= 4'h0;
      reload();
      check({option_byte1, option_byte0}, 16'hFFFF);
      check(trim_working, exp_trim());
      cld(16'hFE60, 8'h5A);
      axi_write(a_pg, 32'h80);
      check(r, ok);
      cld(16'hFE60, 8'hA3);
      // mid-run reset clears the index and reloads everything
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      check(cpu_reset_n, 1'b0);
      aresetn <= 1'b1;
      wait_load();
      check({option_byte1, option_byte0}, 16'hFFFF);
      check(trim_working, exp_trim());
      axi_read(a_idx);
      check(d, 32'h00);
      report_and_stop();
   end
endmodule
